// ==== common/core_pkg.sv ====
/*
 * Constants, phase and instruction class types for the core front end.
 * Assumes one core clock, an active low asynchronous reset, and that
 * every user writes each name as core_pkg::name.
 */
package core_pkg;

    // Quadrature phases, Gray coded so one bit flips per step.
    typedef enum logic [1:0]
    {
        ph_q1 = 2'h0,
        ph_q2 = 2'h1,
        ph_q3 = 2'h3,
        ph_q4 = 2'h2
    } phase_e;

    // Instruction classes that the front end acts on.
    typedef enum logic [3:0]
    {
        op_nop       = 4'h0,
        op_load_bank = 4'h1,
        op_load_w    = 4'h2,
        op_store_w   = 4'h3,
        op_move_f    = 4'h4,
        op_test_skip = 4'h5,
        op_branch    = 4'h6,
        op_jump      = 4'h7,
        op_call      = 4'h8,
        op_load_ptr  = 4'h9,
        op_move_ff   = 4'ha
    } op_e;

    // Program counter and reset values.
    localparam logic [20:0] PC_STEP   = 21'h2;
    localparam logic [20:0] PC_RST    = 21'h0;
    localparam logic [3:0]  BANK_RST  = 4'h0;
    localparam logic [7:0]  W_RST     = 8'h00;
    localparam logic [15:0] IR_RST    = 16'h0000;

    // Bank layout and access map split.
    localparam logic [4:0]  BANKS_ALL   = 5'h10;
    localparam logic [4:0]  BANKS_SMALL = 5'h08;
    localparam logic [7:0]  ACC_SPLIT   = 8'h60;
    localparam logic [3:0]  ACC_LO_BANK = 4'h0;
    localparam logic [3:0]  ACC_HI_BANK = 4'hf;

    // Core registers that live inside this block.
    localparam logic [11:0] ADDR_BANK   = 12'hfe0;
    localparam logic [11:0] ADDR_PCL    = 12'hff9;
    localparam logic [11:0] ADDR_WREG   = 12'hfe8;
    localparam logic [11:0] ADDR_STATUS = 12'hfd8;
    localparam int          STATUS_Z    = 2;

    // Opcode prefixes.
    localparam logic [3:0]  SECOND_TAG   = 4'hf;
    localparam logic [7:0]  LOAD_BANK_HI = 8'h01;
    localparam logic [7:0]  LOAD_W_HI    = 8'h0e;
    localparam logic [6:0]  STORE_W_HI   = 7'h37;
    localparam logic [5:0]  MOVE_F_HI    = 6'h14;
    localparam logic [6:0]  TEST_SKIP_HI = 7'h33;
    localparam logic [4:0]  BRANCH_HI    = 5'h1a;
    localparam logic [7:0]  JUMP_HI      = 8'hef;
    localparam logic [6:0]  CALL_HI      = 7'h76;
    localparam logic [7:0]  LOAD_PTR_HI  = 8'hee;
    localparam logic [3:0]  MOVE_FF_HI   = 4'hc;

endpackage

// ==== dv/mem_partner.sv ====
/*
 * Program memory and banked data RAM facing the core front end.
 * Assumes the bench preloads prog and ram before reset is released.
 */
`timescale 1ns/100ps
module mem_partner
(
    input  wire logic        clk,
    input  wire logic [20:0] prog_addr,
    output logic [15:0]      prog_data,
    input  wire logic [11:0] dmem_addr,
    input  wire logic        dmem_rd,
    output logic [7:0]       dmem_rdata,
    input  wire logic        dmem_wr,
    input  wire logic [7:0]  dmem_wdata,
    output int               wr_cnt
);
    logic [15:0] prog [0:63];
    logic [7:0]  ram  [0:4095];
    logic [7:0]  last_r = 8'h5a;

    // Fetch answers at once; the core samples the word only at the end of Q4.
    assign prog_data = prog[prog_addr[6:1]];

    // Outside a read strobe the bus shows the inverse of the last byte, so stale data fails.
    assign dmem_rdata = dmem_rd ? ram[dmem_addr] : ~last_r;

    // Writes land on the edge that ends Q4; reads remember their byte.
    always @(posedge clk)
    begin
        if (dmem_wr)
        begin
            ram[dmem_addr] <= dmem_wdata;
            wr_cnt         <= wr_cnt + 1;
        end
        if (dmem_rd)
            last_r <= ram[dmem_addr];
    end
endmodule

// ==== dv/tb_core_fetch_and_bank_addressing.sv ====
/*
 * Self-checking bench: runs one small program through the front end and
 * checks data memory, core registers, strobe phases and bubble count.
 * Assumes the small build (eight banks) and the encodings of the core package.
 */
`timescale 1ns/100ps
module tb_core_fetch_and_bank_addressing;
    logic        clk = 1'b0;
    logic        nrst;
    logic [20:0] prog_addr;
    logic [15:0] prog_data;
    logic [11:0] dmem_addr;
    logic        dmem_rd;
    logic [7:0]  dmem_rdata;
    logic        dmem_wr;
    logic [7:0]  dmem_wdata;
    logic [20:0] pc;
    logic [7:0]  bank_select;
    logic [7:0]  w_value;
    logic        zero_flag;
    logic [35:0] pointers;
    logic [1:0]  phase_out;
    logic        flush;
    logic        running = 1'b0;
    logic        arrived = 1'b0;
    logic [1:0]  ph_q = 2'h2;
    int          wr_cnt;
    int          error_cnt = 0;
    int          checked = 0;
    int          flush_cnt = 0;
    logic [15:0] image [0:34] = '{16'h0e5a, 16'h0103, 16'h6f21, 16'h6e10, 16'h6e70,
        16'hc321, 16'hf456, 16'hee1a, 16'hf0bc, 16'h6620, 16'hc010, 16'hf030, 16'hef10,
        16'hf000, 16'h0eee, 16'h0eee, 16'h0109, 16'h6f44, 16'h5144, 16'hd001, 16'h0e11,
        16'h010f, 16'h0e32, 16'h6ff9, 16'h0eee, 16'hec20, 16'hf000, 16'h0eee, 16'h0eee,
        16'h0eee, 16'h0eee, 16'h0eee, 16'h0ef7, 16'h6ee0, 16'hd7ff};

    // Eight ns period.
    always #4 clk = ~clk;

    core_fetch_and_bank_addressing #(.BANKS(core_pkg::BANKS_SMALL))
    u_core_fetch_and_bank_addressing
    (
        .clk         (clk),
        .nrst        (nrst),
        .prog_addr   (prog_addr),
        .prog_data   (prog_data),
        .dmem_addr   (dmem_addr),
        .dmem_rd     (dmem_rd),
        .dmem_rdata  (dmem_rdata),
        .dmem_wr     (dmem_wr),
        .dmem_wdata  (dmem_wdata),
        .pc          (pc),
        .bank_select (bank_select),
        .w_value     (w_value),
        .zero_flag   (zero_flag),
        .pointers    (pointers),
        .phase_out   (phase_out),
        .flush       (flush)
    );

    mem_partner u_mem_partner
    (
        .clk        (clk),
        .prog_addr  (prog_addr),
        .prog_data  (prog_data),
        .dmem_addr  (dmem_addr),
        .dmem_rd    (dmem_rd),
        .dmem_rdata (dmem_rdata),
        .dmem_wr    (dmem_wr),
        .dmem_wdata (dmem_wdata),
        .wr_cnt     (wr_cnt)
    );

    // One comparison of a value, zero extended to the widest result.
    task automatic cmp_vec(input logic [35:0] got, input logic [35:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One comparison of a count kept by the bench.
    task automatic cmp_cnt(input int got, input int exp, input string what);
        checked++;
        if (got != exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Phase order, strobe phases and fetch alignment are watched on every edge.
    // The phase before the first checked edge counts as Q4, so that edge expects Q1.
    always @(posedge clk)
    begin
        if (running)
        begin
            cmp_vec(36'(phase_out), 36'({ph_q[0], ~ph_q[1]}), "phase order");
            cmp_vec(36'(prog_addr[0]), 36'h0, "fetch alignment");
            if (dmem_rd) cmp_vec(36'(phase_out), 36'h1, "read phase");
            if (dmem_wr) cmp_vec(36'(phase_out), 36'h2, "write phase");
            if (phase_out == 2'h1 && flush === 1'b1 && !arrived) flush_cnt++;
            if (prog_addr == 21'h44) arrived <= 1'b1;
            if (phase_out == 2'h1)
                cmp_vec(36'(pc), 36'(prog_addr + 21'h2), "pc step");
            ph_q <= phase_out;
        end
    end

    // Times out a hung run; the program needs well under a thousand clocks.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH t=%0t run did not finish", $time);
        close_out();
    end

    // Loads the program, releases reset and checks the end state.
    initial
    begin
        nrst = 1'b0;
        for (int i = 0; i < 4096; i++) u_mem_partner.ram[i] = 8'h00;
        for (int i = 0; i < 64; i++) u_mem_partner.prog[i] = (i < 35) ? image[i] : 16'h0000;
        u_mem_partner.ram[12'h944] = 8'h33;
        u_mem_partner.ram[12'h030] = 8'h77;
        repeat (16) @(posedge clk);
        nrst    <= 1'b1;
        running <= 1'b1;
        for (int i = 0; i < 2000 && !arrived; i++) @(posedge clk);
        cmp_vec(36'(arrived), 36'h1, "loop reached");
        repeat (16) @(posedge clk);
        cmp_vec(36'(u_mem_partner.ram[12'h321]), 36'h5a, "banked store");
        cmp_vec(36'(u_mem_partner.ram[12'h010]), 36'h5a, "access low");
        cmp_vec(36'(u_mem_partner.ram[12'hf70]), 36'h5a, "access high");
        cmp_vec(36'(u_mem_partner.ram[12'h456]), 36'h5a, "file move");
        cmp_vec(36'(u_mem_partner.ram[12'h944]), 36'h33, "absent bank");
        cmp_vec(36'(u_mem_partner.ram[12'h030]), 36'h77, "lone second word");
        cmp_cnt(wr_cnt, 4, "write strobes");
        $display("test addressing done");
        cmp_vec(pointers, 36'h000abc000, "pointer load");
        cmp_vec(36'(bank_select), 36'h07, "bank select");
        cmp_vec(36'(w_value), 36'hf7, "working value");
        cmp_vec(36'(zero_flag), 36'h1, "zero flag");
        cmp_cnt(flush_cnt, 4, "bubble cycles");
        $display("test flow done");
        close_out();
    end
endmodule

// ==== logic/core_fetch_and_bank_addressing.sv ====
/*
 * Fetch/execute front end: program counter, instruction register,
 * two-word sequencing, branch flush and data address forming.
 * Assumes program memory holds its word for prog_addr by the end of Q4
 * and data memory answers dmem_rdata combinationally during Q2.
 */
`timescale 1ns/100ps
module core_fetch_and_bank_addressing
#(
    parameter logic [4:0] BANKS = core_pkg::BANKS_ALL
)
(
    input  wire logic        clk,
    input  wire logic        nrst,
    output logic [20:0]      prog_addr,
    input  wire logic [15:0] prog_data,
    output logic [11:0]      dmem_addr,
    output logic             dmem_rd,
    input  wire logic [7:0]  dmem_rdata,
    output logic             dmem_wr,
    output logic [7:0]       dmem_wdata,
    output logic [20:0]      pc,
    output logic [7:0]       bank_select,
    output logic [7:0]       w_value,
    output logic             zero_flag,
    output logic [35:0]      pointers,
    output logic [1:0]       phase_out,
    output logic             flush
);

    core_pkg::phase_e phase;
    core_pkg::op_e    cur;
    core_pkg::op_e    pend_op_r;

    logic [20:0] pc_r;
    logic [20:0] prog_addr_r;
    logic [20:0] fetch_addr;
    logic [20:0] jump_addr;
    logic [20:0] br_target;
    logic [20:0] br_off;
    logic [15:0] ir_r;
    logic        ir_nop_r;
    logic        pend_r;
    logic [11:0] pend_lit_r;
    logic [7:0]  ff_data_r;
    logic        second;
    logic [3:0]  bank_r;
    logic [7:0]  w_r;
    logic        z_r;
    logic [11:0] ptr_r [0:2];
    logic [7:0]  oper_r;
    logic [11:0] daddr;
    logic [11:0] dmem_addr_r;
    logic [7:0]  dmem_wdata_r;
    logic [7:0]  wval;
    logic [7:0]  rd_val;
    logic [3:0]  lit4;
    logic        reads;
    logic        writes;
    logic        core_hit;
    logic        impl;
    logic        jump_now;
    logic        br_take;
    logic        skip;
    logic        flush_now;
    logic        is_first;
    logic        q1;
    logic        q2;
    logic        q3;
    logic        q4;
    logic        armed_r;

    q_phase_gen u_phase
    (
        .clk   (clk),
        .nrst  (nrst),
        .phase (phase)
    );

    // Map an instruction word onto the class the front end handles.
    function automatic core_pkg::op_e decode(input logic [15:0] w);
        core_pkg::op_e op;
        op = core_pkg::op_nop;
        if (w[15:8] == core_pkg::LOAD_BANK_HI && w[7:4] == 4'h0)
            op = core_pkg::op_load_bank;
        else if (w[15:8] == core_pkg::LOAD_W_HI)
            op = core_pkg::op_load_w;
        else if (w[15:9] == core_pkg::STORE_W_HI)
            op = core_pkg::op_store_w;
        else if (w[15:10] == core_pkg::MOVE_F_HI)
            op = core_pkg::op_move_f;
        else if (w[15:9] == core_pkg::TEST_SKIP_HI)
            op = core_pkg::op_test_skip;
        else if (w[15:11] == core_pkg::BRANCH_HI)
            op = core_pkg::op_branch;
        else if (w[15:8] == core_pkg::JUMP_HI)
            op = core_pkg::op_jump;
        else if (w[15:9] == core_pkg::CALL_HI)
            op = core_pkg::op_call;
        else if (w[15:8] == core_pkg::LOAD_PTR_HI && w[7:6] == 2'h0 && w[5:4] != 2'h3)
            op = core_pkg::op_load_ptr;
        else if (w[15:12] == core_pkg::MOVE_FF_HI)
            op = core_pkg::op_move_ff;
        return op;
    endfunction

    // Banked or access-mapped address; the extended remap is not built.
    function automatic logic [11:0] file_addr(input logic a,
                                              input logic [7:0] f,
                                              input logic [3:0] bank);
        if (a)
            return {bank, f};
        if (f < core_pkg::ACC_SPLIT)
            return {core_pkg::ACC_LO_BANK, f};
        return {core_pkg::ACC_HI_BANK, f};
    endfunction

    // Registers held in this block rather than in the data memory.
    function automatic logic is_core(input logic [11:0] a);
        return a == core_pkg::ADDR_BANK || a == core_pkg::ADDR_PCL ||
               a == core_pkg::ADDR_WREG || a == core_pkg::ADDR_STATUS;
    endfunction

    // The SFR bank stays present even on builds with fewer banks.
    function automatic logic bank_impl(input logic [3:0] b);
        return ({1'b0, b} < BANKS) || (b == core_pkg::ACC_HI_BANK);
    endfunction

    assign q1 = (phase == core_pkg::ph_q1);
    assign q2 = (phase == core_pkg::ph_q2);
    assign q3 = (phase == core_pkg::ph_q3);
    assign q4 = (phase == core_pkg::ph_q4);
    assign lit4 = ir_r[3:0];

    // Pick the class in execution; a second word alone does nothing.
    always_comb
    begin
        cur = core_pkg::op_nop;
        second = 1'b0;
        if (!ir_nop_r)
        begin
            if (pend_r && ir_r[15:12] == core_pkg::SECOND_TAG)
            begin
                cur = pend_op_r;
                second = 1'b1;
            end
            else if (ir_r[15:12] != core_pkg::SECOND_TAG)
            begin
                cur = decode(ir_r);
            end
            // Otherwise the lone 1111 word stays a no-operation.
        end
    end

    // Address, read/write intent and the value to be written.
    always_comb
    begin
        daddr = file_addr(ir_r[8], ir_r[7:0], bank_r);
        reads = 1'b0;
        writes = 1'b0;
        wval = w_r;
        case (cur)
            core_pkg::op_store_w:
                writes = 1'b1;
            core_pkg::op_move_f:
            begin
                reads = 1'b1;
                writes = ir_r[9];
                wval = oper_r;
            end
            core_pkg::op_test_skip:
                reads = 1'b1;
            core_pkg::op_move_ff:
            begin
                daddr = ir_r[11:0];
                reads = !second;
                writes = second;
                wval = ff_data_r;
            end
            default:
                reads = 1'b0;
        endcase
    end

    assign core_hit = is_core(dmem_addr_r);
    assign impl = bank_impl(dmem_addr_r[11:8]);

    // Strobes go out only for real memory; core registers stay inside.
    assign dmem_rd = q2 && reads && !core_hit && impl;
    assign dmem_wr = q4 && writes && !core_hit && impl;

    // Absent banks read as zero, yet flags still see the value.
    always_comb
    begin
        rd_val = 8'h00;
        if (core_hit)
        begin
            case (dmem_addr_r)
                core_pkg::ADDR_BANK:   rd_val = {4'h0, bank_r};
                core_pkg::ADDR_PCL:    rd_val = pc_r[7:0];
                core_pkg::ADDR_WREG:   rd_val = w_r;
                default:               rd_val = {5'h00, z_r, 2'h0};
            endcase
        end
        else if (impl)
        begin
            rd_val = dmem_rdata;
        end
    end

    // Control flow decisions for this instruction cycle.
    assign is_first = !second && (cur == core_pkg::op_jump ||
                      cur == core_pkg::op_call || cur == core_pkg::op_load_ptr ||
                      cur == core_pkg::op_move_ff);
    assign jump_now = second && (cur == core_pkg::op_jump || cur == core_pkg::op_call);
    assign jump_addr = {ir_r[11:0], pend_lit_r[7:0], 1'b0};
    assign fetch_addr = jump_now ? jump_addr : pc_r;
    assign br_off = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
    assign br_take = (cur == core_pkg::op_branch) ||
                     (writes && dmem_addr_r == core_pkg::ADDR_PCL);
    assign br_target = (cur == core_pkg::op_branch) ? prog_addr_r + br_off
                                                    : {pc_r[20:8], wval[7:1], 1'b0};
    assign skip = (cur == core_pkg::op_test_skip) && (oper_r == 8'h00);
    assign flush_now = br_take || skip;

    // Fetch address moves in Q1; branches reload the counter in Q4.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pc_r <= core_pkg::PC_RST;
            prog_addr_r <= core_pkg::PC_RST;
        end
        else if (q1)
        begin
            prog_addr_r <= fetch_addr;
            pc_r <= fetch_addr + core_pkg::PC_STEP;
        end
        else if (q4 && br_take)
        begin
            pc_r <= br_target;
        end
    end

    // The fetched word lands in the IR; a flush turns it into a bubble.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ir_r <= core_pkg::IR_RST;
            ir_nop_r <= 1'b1;
        end
        else if (q4)
        begin
            ir_r <= prog_data;
            ir_nop_r <= flush_now;
        end
    end

    // First words park their literal until the second word arrives.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_r <= 1'b0;
            pend_op_r <= core_pkg::op_nop;
            pend_lit_r <= 12'h000;
            ff_data_r <= 8'h00;
        end
        else if (q4)
        begin
            pend_r <= is_first;
            pend_op_r <= cur;
            pend_lit_r <= ir_r[11:0];
            ff_data_r <= oper_r;
        end
    end

    // Operand capture at the end of Q2.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            oper_r <= 8'h00;
        end
        else if (q2)
        begin
            oper_r <= rd_val;
        end
    end

    // Data address is set after Q1 and held; write data after Q3.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dmem_addr_r <= 12'h000;
            dmem_wdata_r <= 8'h00;
        end
        else if (q1)
        begin
            dmem_addr_r <= daddr;
        end
        else if (q3)
        begin
            dmem_wdata_r <= wval;
        end
    end

    // Bank select: literal load or write through its data address.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bank_r <= core_pkg::BANK_RST;
        end
        else if (q4 && cur == core_pkg::op_load_bank)
        begin
            bank_r <= ir_r[3:0];
        end
        else if (q4 && writes && dmem_addr_r == core_pkg::ADDR_BANK)
        begin
            bank_r <= wval[3:0];
        end
    end

    // Working register and zero flag; the flag update wins last.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            w_r <= core_pkg::W_RST;
            z_r <= 1'b0;
        end
        else if (q4)
        begin
            if (cur == core_pkg::op_load_w)
                w_r <= ir_r[7:0];
            else if (cur == core_pkg::op_move_f && !ir_r[9])
                w_r <= oper_r;
            else if (writes && dmem_addr_r == core_pkg::ADDR_WREG)
                w_r <= wval;
            if (cur == core_pkg::op_move_f)
                z_r <= (oper_r == 8'h00);
            else if (writes && dmem_addr_r == core_pkg::ADDR_STATUS)
                z_r <= wval[core_pkg::STATUS_Z];
        end
    end

    // Pointer load completes on its second word.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ptr_r[0] <= 12'h000;
            ptr_r[1] <= 12'h000;
            ptr_r[2] <= 12'h000;
        end
        else if (q4 && second && cur == core_pkg::op_load_ptr)
        begin
            ptr_r[pend_lit_r[5:4]] <= {pend_lit_r[3:0], ir_r[7:0]};
        end
    end

    assign prog_addr = prog_addr_r;
    assign dmem_addr = dmem_addr_r;
    assign dmem_wdata = dmem_wdata_r;
    assign pc = pc_r;
    assign bank_select = {4'h0, bank_r};
    assign w_value = w_r;
    assign zero_flag = z_r;
    assign pointers = {ptr_r[2], ptr_r[1], ptr_r[0]};
    assign phase_out = phase;
    assign flush = ir_nop_r;

    // Reset lifts on a clock edge, so checks wait one edge for the state to leave reset.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            armed_r <= 1'b0;
        else
            armed_r <= 1'b1;
    end

    // Checks on the sequencing and addressing behaviour.
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!nrst || !armed_r);

    sequence s_quad;
        q1 ##1 q2 ##1 q3 ##1 q4;
    endsequence

    sequence s_bubble;
        (ir_nop_r && cur == core_pkg::op_nop) [*4];
    endsequence

    property p_quad;
        q1 |-> s_quad ##1 q1;
    endproperty
    a_quad: assert property (p_quad) else $error("phase order broken");

    property p_even;
        pc_r[0] == 1'b0 && prog_addr_r[0] == 1'b0;
    endproperty
    a_even: assert property (p_even) else $error("odd program address");

    property p_step;
        (q1 && !jump_now) |=> prog_addr_r == $past(pc_r) && pc_r == prog_addr_r + 21'h2;
    endproperty
    a_step: assert property (p_step) else $error("pc did not step by two");

    property p_jump;
        (q1 && jump_now) |=> prog_addr_r == $past(jump_addr) ##3 !ir_nop_r;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or bubble wrong");

    property p_branch;
        (q4 && br_take) |=> pc_r == $past(br_target) ##0 s_bubble;
    endproperty
    a_branch: assert property (p_branch) else $error("branch not flushed");

    property p_quiet;
        (q4 && ir_nop_r) |-> !dmem_wr ##1 z_r == $past(z_r) && bank_r == $past(bank_r);
    endproperty
    a_quiet: assert property (p_quiet) else $error("flushed word had effect");

    property p_strobe;
        (dmem_rd -> q2) && (dmem_wr -> q4);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe in wrong phase");

    property p_absent;
        (q2 && reads && !core_hit && !impl) |=> oper_r == 8'h00 ##1 !dmem_wr;
    endproperty
    a_absent: assert property (p_absent) else $error("absent bank not zero");

    property p_upper;
        bank_select[7:4] == 4'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("bank select upper bits set");

    property p_lbank;
        (q4 && cur == core_pkg::op_load_bank) |=> bank_select[3:0] == $past(lit4);
    endproperty
    a_lbank: assert property (p_lbank) else $error("bank literal not loaded");

    property p_access;
        (q2 && reads && cur != core_pkg::op_move_ff && !ir_r[8]) |->
            dmem_addr_r[7:0] == ir_r[7:0] &&
            dmem_addr_r[11:8] == ((ir_r[7:0] < 8'h60) ? 4'h0 : 4'hf);
    endproperty
    a_access: assert property (p_access) else $error("access map wrong");

    property p_lone;
        (q1 && !ir_nop_r && !pend_r && ir_r[15:12] == 4'hf) |->
            cur == core_pkg::op_nop ##3 !dmem_wr && !br_take;
    endproperty
    a_lone: assert property (p_lone) else $error("lone second word acted");

endmodule

// ==== logic/q_phase_gen.sv ====
/*
 * Quadrature phase sequencer: four core clocks make one instruction cycle.
 * Assumes the core clock runs free and reset is asynchronous active low.
 */
`timescale 1ns/100ps
module q_phase_gen
(
    input  wire logic        clk,
    input  wire logic        nrst,
    output core_pkg::phase_e phase
);

    core_pkg::phase_e phase_r;

    // Walk Q1 to Q4 and wrap; reset always lands on Q1.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_r <= core_pkg::ph_q1;
        end
        else
        begin
            case (phase_r)
                core_pkg::ph_q1: phase_r <= core_pkg::ph_q2;
                core_pkg::ph_q2: phase_r <= core_pkg::ph_q3;
                core_pkg::ph_q3: phase_r <= core_pkg::ph_q4;
                core_pkg::ph_q4: phase_r <= core_pkg::ph_q1;
                default:         phase_r <= core_pkg::ph_q1;
            endcase
        end
    end

    assign phase = phase_r;

endmodule
